/* File: core/rwd_consts.vh */
// Constants for the runaway watchdog timer: offsets, fields, codes, times
`ifndef RWD_CONSTS_VH
`define RWD_CONSTS_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define RWD_IDX_W          10
`define RWD_IDX_MODE       10'h05C
`define RWD_IDX_CMD        10'h05D
`define RWD_IDX_STATUS     10'h05E
`define RWD_IDX_AUX        10'h05F
`define RWD_ADDR_W         12

// ************************************************************
// Mode register fields
// ************************************************************
`define RWD_MODE_EN_BIT    7
`define RWD_MODE_DET_HI    6
`define RWD_MODE_DET_LO    5
`define RWD_MODE_WARM_BIT  4
`define RWD_MODE_STBY_HI   3
`define RWD_MODE_STBY_LO   2
`define RWD_MODE_LINK_BIT  1
`define RWD_MODE_DRV_BIT   0
`define RWD_MODE_RESET     8'h80

// ************************************************************
// Standby mode codes
// ************************************************************
`define RWD_STBY_RUN       2'h0
`define RWD_STBY_STOP      2'h1
`define RWD_STBY_IDLE_OSC  2'h2
`define RWD_STBY_IDLE_CORE 2'h3

// ************************************************************
// Command codes
// ************************************************************
`define RWD_CMD_DISABLE    8'hB1
`define RWD_CMD_CLEAR      8'h4E

// ************************************************************
// Counter taps as powers of two of the system clock
// ************************************************************
`define RWD_CNT_W          22
`define RWD_DET_EXP0       15
`define RWD_DET_EXP1       17
`define RWD_DET_EXP2       19
`define RWD_DET_EXP3       21
`define RWD_WARM_EXP_SHORT 14
`define RWD_WARM_EXP_LONG  16
`define RWD_WARM_EXP_FAST  7

// ************************************************************
// Timing
// ************************************************************
`define RWD_CLK_NS         50
`define RWD_RST_LOW_NS     12800
`define RWD_RST_CYC ((`RWD_RST_LOW_NS + `RWD_CLK_NS - 1) / `RWD_CLK_NS)

`endif

/* File: core/rwd_tap_counter.v */
// Binary up-counter with a selectable power-of-two terminal tap
`timescale 1ns/1ns
module rwd_tap_counter #(
  parameter CNT_W = 22
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             ce,
  input  wire             clr,
  input  wire             run,
  input  wire [4:0]       tap_exp,
  output wire             hit,
  output wire [CNT_W-1:0] count
);

  reg  [CNT_W-1:0] count_r;
  reg  [CNT_W-1:0] count_nxt;
  wire [CNT_W-1:0] one;
  wire [CNT_W-1:0] tap_last;

  assign one      = {{(CNT_W-1){1'b0}}, 1'b1};
  assign tap_last = (one << tap_exp) - one;
  // Pulse on the last count before the selected bit would rise
  assign hit      = run & ~clr & (count_r == tap_last);
  assign count    = count_r;

  // Clear wins over counting so a fresh full period follows it
  always @* begin
    count_nxt = count_r;
    if (clr) begin
      count_nxt = {CNT_W{1'b0}};
    end else if (run) begin
      count_nxt = count_r + one;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= {CNT_W{1'b0}};
    end else if (ce) begin
      count_r <= count_nxt;
    end
  end

endmodule

/* File: core/rwd_watchdog.v */
// Runaway watchdog timer with warm-up timer and APB register slave
//
// What this block does
// - Mode bit routes watchdog overflow onto the chip reset.
// - Reset-link bit clears to zero on reset.
// - Disable code stops watchdog only after enable bit was cleared.
// - Setting the enable bit re-enables the watchdog directly.
// - Clear code zeroes the counter; counting resumes at once.
// - Detection field selects 2^15, 2^17, 2^19 or 2^21 clocks.
// - Elapsed detection time raises interrupt and drives output low.
// - Interrupt comes from counter overflow without a timely clear.
// - Watchdog counts from reset release without software action.
// - Counter halts in oscillator-only standby and in stop.
// - Counter keeps running in run standby.
// - Counter keeps running while the bus is released.
// - In core-and-converter standby counter runs, interrupt suppressed.
// - Two-bit standby field: run, stop, oscillator-only, core standby.
// - Warm-up bit picks short or four-times tap; fast bit shortest.
// - Output pin stays low until clear code after a disable.
// - With reset link, output pulses low briefly, then self-resets.
// - Enable bit initialises to one on reset.
// - Detection field initialises to 00 on reset.
`timescale 1ns/1ns
`include "rwd_consts.vh"
module rwd_watchdog #(
  parameter DET_EXP0   = `RWD_DET_EXP0,
  parameter DET_EXP1   = `RWD_DET_EXP1,
  parameter DET_EXP2   = `RWD_DET_EXP2,
  parameter DET_EXP3   = `RWD_DET_EXP3,
  parameter WARM_SHORT = `RWD_WARM_EXP_SHORT,
  parameter WARM_LONG  = `RWD_WARM_EXP_LONG,
  parameter WARM_FAST  = `RWD_WARM_EXP_FAST
) (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   ce,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`RWD_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output wire [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  input  wire                   halt_active,
  input  wire                   warmup_start,
  output wire                   watchdog_overflow_irq,
  output wire                   watchdog_output_pin_n,
  output wire                   chip_reset_req,
  output wire                   warmup_busy,
  output wire                   warmup_done,
  output wire [1:0]             standby_mode_select,
  output wire                   pin_drive_in_stop
);

  // ************************************************************
  // Register select decoding
  // ************************************************************
  localparam SEL_NONE   = 3'd0;
  localparam SEL_MODE   = 3'd1;
  localparam SEL_CMD    = 3'd2;
  localparam SEL_STATUS = 3'd3;
  localparam SEL_AUX    = 3'd4;
  localparam integer RST_LAST_I = `RWD_RST_CYC - 1;
  localparam [9:0]   RST_LAST   = RST_LAST_I[9:0];

  function [2:0] reg_sel;
    input [`RWD_ADDR_W-1:0] addr;
    begin
      reg_sel = SEL_NONE;
      if (addr[1:0] == 2'h0) begin
        case (addr[`RWD_ADDR_W-1:2])
          `RWD_IDX_MODE:   reg_sel = SEL_MODE;
          `RWD_IDX_CMD:    reg_sel = SEL_CMD;
          `RWD_IDX_STATUS: reg_sel = SEL_STATUS;
          `RWD_IDX_AUX:    reg_sel = SEL_AUX;
          default:         reg_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  function [4:0] det_exp;
    input [1:0] code;
    begin
      case (code)
        2'h0:    det_exp = DET_EXP0[4:0];
        2'h1:    det_exp = DET_EXP1[4:0];
        2'h2:    det_exp = DET_EXP2[4:0];
        default: det_exp = DET_EXP3[4:0];
      endcase
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  reg  [7:0]  mode_r;
  reg  [7:0]  mode_nxt;
  reg         aux_fast_r;
  reg         aux_fast_nxt;
  reg         active_r;
  reg         active_nxt;
  reg         pin_low_r;
  reg         pin_low_nxt;
  reg         irq_r;
  reg         irq_nxt;
  reg         rst_pulse_r;
  reg         rst_pulse_nxt;
  reg  [9:0]  rst_cnt_r;
  reg  [9:0]  rst_cnt_nxt;
  reg         warm_busy_r;
  reg         warm_busy_nxt;
  reg         warm_done_r;
  reg         warm_done_nxt;
  reg  [31:0] rdata_r;
  reg  [31:0] rdata_nxt;

  wire [2:0]  sel;
  wire        setup_ph;
  wire        wr_acc;
  wire        wr_mode;
  wire        wr_cmd;
  wire        wr_aux;
  wire        cmd_clear;
  wire        cmd_disable;
  wire        soft_rst;
  wire        stby_halts;
  wire        stby_quiet;
  wire        wd_run;
  wire        wd_clr;
  wire        wd_hit;
  wire        overflow;
  wire [4:0]  warm_exp;
  wire        warm_hit;

  // ************************************************************
  // APB slave
  // ************************************************************
  // Zero wait states while enabled; a frozen block stalls the bus
  assign sel      = reg_sel(paddr);
  assign setup_ph = psel & ~penable;
  assign pready   = ce;
  assign pslverr  = psel & penable & (reg_sel(paddr) == SEL_NONE);
  assign wr_acc   = psel & penable & pwrite & ce;
  assign wr_mode  = wr_acc & (sel == SEL_MODE);
  assign wr_cmd   = wr_acc & (sel == SEL_CMD);
  assign wr_aux   = wr_acc & (sel == SEL_AUX);
  assign prdata   = rdata_r;

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always @* begin
    rdata_nxt = rdata_r;
    if (setup_ph && !pwrite) begin
      case (sel)
        SEL_MODE:   rdata_nxt = {24'h000000, mode_r};
        SEL_STATUS: rdata_nxt = {27'h0000000, warm_busy_r, rst_pulse_r,
                                 pin_low_r, active_r, wd_run};
        SEL_AUX:    rdata_nxt = {31'h00000000, aux_fast_r};
        default:    rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // Command decode
  // ************************************************************
  assign cmd_clear   = wr_cmd & (pwdata[7:0] == `RWD_CMD_CLEAR);
  assign cmd_disable = wr_cmd & (pwdata[7:0] == `RWD_CMD_DISABLE);

  // ************************************************************
  // Watchdog counter
  // ************************************************************
  // Halt only counts when the halt is actually in progress
  assign stby_halts = halt_active &
                      ((mode_r[3:2] == `RWD_STBY_STOP) |
                       (mode_r[3:2] == `RWD_STBY_IDLE_OSC));
  assign stby_quiet = halt_active &
                      (mode_r[3:2] == `RWD_STBY_IDLE_CORE);
  // Run standby and bus release do not stop the count
  assign wd_run     = active_r & ~stby_halts & ~rst_pulse_r;
  assign wd_clr     = cmd_clear | soft_rst;
  assign overflow   = wd_hit & ~stby_quiet;
  assign soft_rst   = rst_pulse_r & (rst_cnt_r == RST_LAST);

  rwd_tap_counter #(
    .CNT_W (`RWD_CNT_W)
  ) u_wd_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clr     (wd_clr),
    .run     (wd_run),
    .tap_exp (det_exp(mode_r[6:5])),
    .hit     (wd_hit),
    .count   ()
  );

  // ************************************************************
  // Warm-up counter
  // ************************************************************
  // Fast select overrides the warm bit; it shares no taps here, so
  // the watchdog period is unaffected by it
  assign warm_exp = aux_fast_r ? WARM_FAST[4:0] :
                    (mode_r[`RWD_MODE_WARM_BIT] ? WARM_LONG[4:0] :
                                                  WARM_SHORT[4:0]);

  rwd_tap_counter #(
    .CNT_W (`RWD_CNT_W)
  ) u_warm_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clr     (warmup_start | soft_rst),
    .run     (warm_busy_r),
    .tap_exp (warm_exp),
    .hit     (warm_hit),
    .count   ()
  );

  always @* begin
    warm_busy_nxt = warm_busy_r;
    warm_done_nxt = 1'b0;
    if (soft_rst) begin
      warm_busy_nxt = 1'b0;
    end else if (warmup_start) begin
      warm_busy_nxt = 1'b1;
    end else if (warm_hit) begin
      warm_busy_nxt = 1'b0;
      warm_done_nxt = 1'b1;
    end
  end

  // ************************************************************
  // Mode, enable and output control
  // ************************************************************
  always @* begin
    mode_nxt     = mode_r;
    aux_fast_nxt = aux_fast_r;
    active_nxt   = active_r;
    if (wr_mode) begin
      mode_nxt = pwdata[7:0];
      if (pwdata[`RWD_MODE_EN_BIT]) begin
        active_nxt = 1'b1;
      end
    end
    // Disable code counts only against the enable bit already stored
    if (cmd_disable && !mode_r[`RWD_MODE_EN_BIT]) begin
      active_nxt = 1'b0;
    end
    if (wr_aux) begin
      aux_fast_nxt = pwdata[0];
    end
    if (soft_rst) begin
      mode_nxt     = `RWD_MODE_RESET;
      aux_fast_nxt = 1'b0;
      active_nxt   = 1'b1;
    end
  end

  // Overflow sets the pin latch; a clear after a disable releases it.
  // A coinciding overflow wins over the release.
  always @* begin
    pin_low_nxt   = pin_low_r;
    irq_nxt       = 1'b0;
    rst_pulse_nxt = rst_pulse_r;
    rst_cnt_nxt   = rst_cnt_r;
    if (cmd_clear && !active_r) begin
      pin_low_nxt = 1'b0;
    end
    if (overflow) begin
      pin_low_nxt = 1'b1;
      irq_nxt     = 1'b1;
      if (mode_r[`RWD_MODE_LINK_BIT]) begin
        rst_pulse_nxt = 1'b1;
        rst_cnt_nxt   = 10'h000;
      end
    end
    if (rst_pulse_r) begin
      rst_cnt_nxt = rst_cnt_r + 10'h001;
      if (soft_rst) begin
        rst_pulse_nxt = 1'b0;
        pin_low_nxt   = 1'b0;
        rst_cnt_nxt   = 10'h000;
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r      <= `RWD_MODE_RESET;
      aux_fast_r  <= 1'b0;
      active_r    <= 1'b1;
      pin_low_r   <= 1'b0;
      irq_r       <= 1'b0;
      rst_pulse_r <= 1'b0;
      rst_cnt_r   <= 10'h000;
      warm_busy_r <= 1'b0;
      warm_done_r <= 1'b0;
      rdata_r     <= 32'h00000000;
    end else if (ce) begin
      mode_r      <= mode_nxt;
      aux_fast_r  <= aux_fast_nxt;
      active_r    <= active_nxt;
      pin_low_r   <= pin_low_nxt;
      irq_r       <= irq_nxt;
      rst_pulse_r <= rst_pulse_nxt;
      rst_cnt_r   <= rst_cnt_nxt;
      warm_busy_r <= warm_busy_nxt;
      warm_done_r <= warm_done_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign watchdog_overflow_irq = irq_r;
  assign watchdog_output_pin_n = ~pin_low_r;
  assign chip_reset_req        = rst_pulse_r;
  assign warmup_busy           = warm_busy_r;
  assign warmup_done           = warm_done_r;
  assign standby_mode_select   = mode_r[3:2];
  assign pin_drive_in_stop     = mode_r[`RWD_MODE_DRV_BIT];

endmodule

/* File: tb/rwd_properties.sv */
// Port-level property checker for the runaway watchdog timer
`timescale 1ns/1ns
module rwd_properties (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        halt_active,
  input wire        warmup_start,
  input wire        watchdog_overflow_irq,
  input wire        watchdog_output_pin_n,
  input wire        chip_reset_req,
  input wire        warmup_busy,
  input wire        warmup_done,
  input wire [1:0]  standby_mode_select
);
  // ****************
  // Properties
  // ****************
  wire       irq   = watchdog_overflow_irq;
  wire       pin_n = watchdog_output_pin_n;
  wire [1:0] sm    = standby_mode_select;
  // Only the four word-aligned register offsets are mapped
  wire       mapped = paddr[1:0] == 2'h0 && paddr[11:4] == 8'h17;
  wire       frozen = halt_active && (sm == 2'h1 || sm == 2'h2);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_ce: assert property (pready == ce)
    else $error("pready does not follow ce");
  a_err_map: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr wrong for address");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_irq_pin_low: assert property (irq |-> !pin_n)
    else $error("overflow pulse without low output");
  a_pin_fall: assert property ($fell(pin_n) |-> irq)
    else $error("output fell without overflow pulse");
  a_irq_single: assert property (irq |=> !irq)
    else $error("overflow pulse longer than one cycle");
  a_link_pin: assert property (chip_reset_req |-> !pin_n)
    else $error("reset request while output high");
  a_link_min: assert property (
    $rose(chip_reset_req) |-> chip_reset_req[*8])
    else $error("reset pulse shorter than eight cycles");
  a_halt_quiet: assert property (frozen[*3] |-> !irq)
    else $error("overflow while counter halted");
  a_core_quiet: assert property (
    (halt_active && sm == 2'h3)[*3] |-> !irq && !$fell(pin_n))
    else $error("overflow not suppressed in core standby");
  a_warm_busy: assert property (
    warmup_start && ce |=> warmup_busy)
    else $error("warm-up start did not set busy");
  a_warm_done: assert property (
    warmup_done |-> !warmup_busy ##1 !warmup_done)
    else $error("warm-up done pulse malformed");
  c_irq: cover property (irq);
  c_link: cover property ($rose(chip_reset_req));
  c_warm: cover property (warmup_done);
endmodule

/* File: tb/rwd_watchdog_tb.sv */
// Self-checking bench for the runaway watchdog timer
`timescale 1ns/1ns
`include "rwd_consts.vh"
`define CHK(got, exp) \
  begin \
    num_checks = num_checks + 1; \
    if ((got) !== (exp)) begin \
      fail_count = fail_count + 1; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module rwd_watchdog_tb;
  // ****************
  // Harness
  // ****************
  // Small taps keep every detection period between 8 and 64 cycles long
  localparam integer D0 = 3;
  localparam integer WS = 3;
  localparam integer WL = 5;
  localparam integer WF = 2;
  localparam [11:0] A_MODE = {`RWD_IDX_MODE, 2'h0};
  localparam [11:0] A_CMD  = {`RWD_IDX_CMD, 2'h0};
  localparam [11:0] A_AUX  = {`RWD_IDX_AUX, 2'h0};
  reg         pclk, presetn, psel, penable, pwrite, halt_active, w_start, ce;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, pin_n, rst_req, busy, done, pdrv;
  wire [1:0]  sm;
  integer     fail_count, num_checks;
  integer     irqs = 0;

  rwd_watchdog #(
    .DET_EXP0(D0), .DET_EXP1(D0 + 1), .DET_EXP2(D0 + 2), .DET_EXP3(D0 + 3),
    .WARM_SHORT(WS), .WARM_LONG(WL), .WARM_FAST(WF)
  ) uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_active(halt_active), .warmup_start(w_start),
    .watchdog_overflow_irq(irq), .watchdog_output_pin_n(pin_n),
    .chip_reset_req(rst_req), .warmup_busy(busy), .warmup_done(done),
    .standby_mode_select(sm), .pin_drive_in_stop(pdrv)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) if (irq === 1'b1) irqs <= irqs + 1;

  task close_out;
    begin
      if (fail_count == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task apb(input reg wr, input reg [11:0] a, input reg [7:0] d);
    integer n;
    begin
      // Leading edge wait keeps psel low one cycle between calls
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      // Answer is taken at the very edge that samples pready high
      while (pready !== 1'b1 && n < 50) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 50) begin
        fail_count = fail_count + 1;
        close_out;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
    end
  endtask

  task wait_irq(input integer exp);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n = n + 1;
      end while (irq !== 1'b1 && n < 300);
      `CHK(n, exp)
      if (n >= 300) close_out;
    end
  endtask

  task recover;
    begin
      apb(1'b1, A_MODE, 8'h00);
      apb(1'b1, A_CMD, 8'hB1);
      apb(1'b1, A_CMD, 8'h4E);
      `CHK(pin_n, 1'b1)
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  task t_boot;
    begin
      wait_irq(1 << D0);
      apb(1'b0, A_MODE, 8'h00);
      `CHK(rd, 32'h80)
      apb(1'b1, A_MODE + 12'h1, 8'h00);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h180, 8'h00);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b0, A_MODE, 8'h00);
      `CHK(rd, 32'h80)
      recover;
    end
  endtask

  task t_detect;
    integer s;
    begin
      for (s = 0; s < 4; s = s + 1) begin
        apb(1'b1, A_MODE, {1'b1, s[1:0], 5'h00});
        apb(1'b1, A_CMD, 8'h4E);
        wait_irq(1 << (D0 + s));
        `CHK(pin_n, 1'b0)
        apb(1'b1, A_CMD, 8'h4E);
        `CHK(pin_n, 1'b0)
        recover;
      end
    end
  endtask

  task t_cmd;
    integer k;
    begin
      apb(1'b1, A_MODE, 8'h80);
      k = irqs;
      repeat (4) apb(1'b1, A_CMD, 8'h4E);
      `CHK(irqs - k, 0)
      apb(1'b1, A_CMD, 8'h4E);
      apb(1'b1, A_CMD, 8'hB1);
      apb(1'b1, A_CMD, 8'h55);
      wait_irq((1 << D0) - 6);
      apb(1'b1, A_CMD, 8'h4E);
      // Enable low for ten edges holds the count, so the period stretches
      @(posedge pclk);
      ce <= 1'b0;
      repeat (10) @(posedge pclk);
      ce <= 1'b1;
      #1;
      wait_irq((1 << D0) - 1);
      recover;
      k = irqs;
      repeat (40) @(posedge pclk);
      #1;
      `CHK(irqs, k)
    end
  endtask

  task t_stby;
    integer c, k;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        apb(1'b1, A_MODE, {4'h8, c[1:0], 1'b0, c[0]});
        `CHK({sm, pdrv}, {c[1:0], c[0]})
        @(posedge pclk);
        halt_active <= 1'b1;
        k = irqs;
        apb(1'b1, A_CMD, 8'h4E);
        repeat (20) @(posedge pclk);
        halt_active <= 1'b0;
        #1;
        `CHK(irqs - k, c == 0)
        `CHK(pin_n, c != 0)
        if (c == 1 || c == 2)
          wait_irq(1 << D0);
        recover;
      end
      // Disabled before core standby: the count must not restart after it
      apb(1'b1, A_MODE, 8'h0C);
      k = irqs;
      @(posedge pclk);
      halt_active <= 1'b1;
      repeat (2) @(posedge pclk);
      halt_active <= 1'b0;
      repeat (20) @(posedge pclk);
      #1;
      `CHK(irqs - k, 0)
    end
  endtask

  task t_warm;
    integer i, n;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        apb(1'b1, A_MODE, {3'h0, i == 1, 4'h0});
        apb(1'b1, A_AUX, {7'h0, i == 2});
        apb(1'b0, A_AUX, 8'h00);
        `CHK(rd, {31'h0, i == 2})
        @(posedge pclk);
        w_start <= 1'b1;
        @(posedge pclk);
        w_start <= 1'b0;
        #1;
        `CHK(busy, 1'b1)
        n = 0;
        while (done !== 1'b1 && n < 100) begin
          @(posedge pclk);
          #1;
          n = n + 1;
        end
        `CHK(n, 1 << (i == 0 ? WS : i == 1 ? WL : WF))
        `CHK(busy, 1'b0)
        if (n >= 100) close_out;
      end
      apb(1'b1, A_AUX, 8'h00);
    end
  endtask

  task t_link;
    integer n;
    begin
      apb(1'b1, A_MODE, 8'h82);
      apb(1'b1, A_CMD, 8'h4E);
      wait_irq(1 << D0);
      `CHK({pin_n, rst_req}, 2'h1)
      n = 0;
      while (rst_req === 1'b1 && n < 400) begin
        @(posedge pclk);
        #1;
        n = n + 1;
      end
      `CHK(n >= `RWD_RST_CYC - 1 && n <= `RWD_RST_CYC + 1, 1'b1)
      `CHK(pin_n, 1'b1)
      if (n >= 400) close_out;
      apb(1'b0, A_MODE, 8'h00);
      `CHK(rd, 32'h80)
    end
  endtask

  initial begin
    fail_count = 0;
    num_checks = 0;
    ce = 1'b1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    halt_active = 1'b0;
    w_start = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_boot;
    t_detect;
    t_cmd;
    t_stby;
    t_warm;
    t_link;
    close_out;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count = fail_count + 1;
    close_out;
  end
endmodule

bind rwd_watchdog rwd_properties chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .halt_active(halt_active),
  .warmup_start(warmup_start), .warmup_busy(warmup_busy),
  .warmup_done(warmup_done), .chip_reset_req(chip_reset_req),
  .watchdog_overflow_irq(watchdog_overflow_irq),
  .watchdog_output_pin_n(watchdog_output_pin_n),
  .standby_mode_select(standby_mode_select)
);
